/* rtl/rerp_pkg.sv */
// Purpose: shared constants for the read error recovery policy block
// Assumes: 20 MHz controller clock, mode page bytes delivered by firmware
// Notes: offsets are register indices on the plain register port
package rerp_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [3:0] RERP_ADR_FLAGS = 4'h0;
  localparam logic [3:0] RERP_ADR_RD_RETRY = 4'h1;
  localparam logic [3:0] RERP_ADR_SPAN = 4'h2;
  localparam logic [3:0] RERP_ADR_HEAD_OFS = 4'h3;
  localparam logic [3:0] RERP_ADR_STROBE_OFS = 4'h4;
  localparam logic [3:0] RERP_ADR_WR_RETRY = 4'h5;
  localparam logic [3:0] RERP_ADR_TIME_LIMIT = 4'h6;
  localparam logic [3:0] RERP_ADR_CHANGEABLE = 4'h7;
  localparam logic [3:0] RERP_ADR_STATUS = 4'h8;
  localparam logic [3:0] RERP_ADR_SENSE_LBA = 4'h9;
  localparam logic [3:0] RERP_ADR_SENSE = 4'hA;
  // ------------------------------------------------------------
  // Flag byte field positions
  // ------------------------------------------------------------
  localparam int RERP_BIT_DCR = 0;
  localparam int RERP_BIT_DTE = 1;
  localparam int RERP_BIT_PER = 2;
  localparam int RERP_BIT_EEC = 3;
  localparam int RERP_BIT_RC = 4;
  localparam int RERP_BIT_TB = 5;
  // ------------------------------------------------------------
  // Reset values and limits
  // ------------------------------------------------------------
  localparam logic [7:0] RERP_RST_FLAGS = 8'h00;
  localparam logic [7:0] RERP_RST_RD_RETRY = 8'h0A;
  localparam logic [7:0] RERP_RST_WR_RETRY = 8'h04;
  localparam logic [7:0] RERP_RST_SPAN = 8'h0B;
  localparam logic [7:0] RERP_MAX_SPAN = 8'h14;
  localparam logic [7:0] RERP_RST_HEAD_OFS = 8'h02;
  localparam logic [7:0] RERP_RST_STROBE_OFS = 8'h02;
  localparam logic [7:0] RERP_MAX_STROBE_OFS = 8'h02;
  localparam logic [7:0] RERP_TIME_LIMIT = 8'h00;
  localparam logic [7:0] RERP_CHANGEABLE = 8'h3F;
  localparam logic [7:0] RERP_ON_TRACK_TRIES = 8'h04;
  localparam logic [7:0] RERP_EARLY_TRIES = 8'h01;
  localparam logic [15:0] RERP_INVALID_MAP = 16'hAE0C;
  // Sense keys / ASC: bad flag combination, recovered error, medium error
  localparam logic [3:0] RERP_KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] RERP_ASC_INV_PARAM = 8'h26;
  localparam logic [3:0] RERP_KEY_RECOVERED = 4'h1;
  localparam logic [3:0] RERP_KEY_MEDIUM = 4'h3;
  // ------------------------------------------------------------
  // Sector recovery states and offset positions
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RERP_IDLE = 3'b000,
    RERP_RETRY = 3'b001,
    RERP_CORRECT = 3'b011,
    RERP_DONE = 3'b010
  } rerp_state_t;
  typedef enum logic [1:0] {
    RERP_POS_CENTER = 2'b00,
    RERP_POS_HEAD = 2'b01,
    RERP_POS_STROBE = 2'b11
  } rerp_pos_t;
endpackage : rerp_pkg

/* rtl/rerp_step.sv */
// Purpose: offset plan for one recovery attempt number
// Assumes: attempt counts from zero within one sector
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module rerp_step (
  input wire logic [7:0] attempt,
  input wire logic [7:0] head_count,
  input wire logic [7:0] strobe_count,
  output rerp_pkg::rerp_pos_t pos,
  output logic neg_dir
);
  import rerp_pkg::*;
  logic [8:0] rel;
  // ------------------------------------------------------------
  // Position select
  // ------------------------------------------------------------
  always_comb begin
    rel = {1'b0, attempt} - {1'b0, RERP_ON_TRACK_TRIES};
    pos = RERP_POS_CENTER;
    neg_dir = 1'b0;
    if (attempt >= RERP_ON_TRACK_TRIES &&
        rel < {1'b0, head_count[7:1], 1'b0}) begin
      pos = RERP_POS_HEAD;
      neg_dir = rel[0];
    end else if (attempt >= RERP_ON_TRACK_TRIES &&
        rel < {1'b0, head_count[7:1], 1'b0} + {1'b0, strobe_count}) begin
      pos = RERP_POS_STROBE;
      neg_dir = rel[0];
    end
  end
endmodule : rerp_step
`default_nettype wire

/* rtl/rerp_core.sv */
// Purpose: read/write error recovery policy for the drive controller
// Assumes: firmware loads mode page bytes over the register port
// Notes: sector status comes from the read channel on clk_sys
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Post flag set: recovered errors reported, timing chosen by stop flag
// - Sense holds last recovered block or first unrecoverable block
// - Changeable values read one in all six flag bits (3Fh), post, stop and no-correction among them
// - Stop and post set: end at once with check condition
// - Stop flag clear: keep transferring after recoverable error
// - No-correction set: skip ECC, correctable error counts recoverable
// - Bad flag combination gives illegal request, invalid parameter field
// - Retry counts 0 to 255, defaults 10 read and 4 write
// - Correction span 11 to 20, zero means default 11
// - After four on-track tries, offset +1 and -1 pairs
// - Strobe offset count 0 to 2, default 2
// - Recovery time limit always reads 00h
// - Seven listed flag combinations are invalid
// - Without early correction all retries precede correction
// - Early correction uses a minimum retry count first
// - Unrecoverable error stops transfer in every mode except continuous read
// - Valid stop modes end transfer early on any error
// - Early flag decides whether retries are exhausted first
// - Pass-bad-block flag decides whether failing block is sent
// - Continuous read ignores flags, disables retries and correction
module rerp_core (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sec_start,
  input wire logic sec_is_write,
  input wire logic [15:0] sec_lba,
  input wire logic try_done,
  input wire logic try_ok,
  input wire logic try_ecc_fixable,
  output logic try_req,
  output rerp_pkg::rerp_pos_t try_pos,
  output logic try_neg,
  output logic ecc_req,
  output logic [7:0] ecc_span,
  output logic sec_done,
  output logic sec_send,
  output logic xfer_stop,
  output logic check_cond,
  output logic param_reject
);
  import rerp_pkg::*;
  logic [7:0] flags_q, flags_d, rd_retry_q, rd_retry_d, wr_retry_q;
  logic [7:0] wr_retry_d, span_q, span_d, head_q, head_d, strobe_q;
  logic [7:0] strobe_d, rdata_q, rdata_d, att_q, att_d;
  logic [15:0] lba_q, lba_d, sense_lba_q, sense_lba_d;
  logic [3:0] key_q, key_d;
  logic [7:0] asc_q, asc_d;
  logic sense_fatal_q, sense_fatal_d, wr_op_q, wr_op_d;
  rerp_state_t st_q, st_d;
  logic try_req_q, try_req_d, ecc_q, ecc_d, done_q, done_d, send_q;
  logic send_d, stop_q, stop_d, chk_q, chk_d, rej_q, rej_d;
  rerp_pos_t pos_q, pos_d;
  logic neg_q, neg_d;
  logic rc, eec, per, stop_on_error_flag, no_correction_flag, tb, mode_ok;
  logic [7:0] limit;

  // Invalid mode table indexed by {early, post, stop, no-corr}
  function automatic logic mode_bad(input logic [7:0] f);
    logic [3:0] idx;
    idx = {f[RERP_BIT_EEC], f[RERP_BIT_PER], f[RERP_BIT_DTE],
           f[RERP_BIT_DCR]};
    return RERP_INVALID_MAP[idx];
  endfunction : mode_bad

  rerp_step u_step (
    .attempt(att_d),
    .head_count(head_q),
    .strobe_count(strobe_q),
    .pos(pos_d),
    .neg_dir(neg_d)
  );

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  always_comb begin
    flags_d = flags_q;
    rd_retry_d = rd_retry_q;
    wr_retry_d = wr_retry_q;
    span_d = span_q;
    head_d = head_q;
    strobe_d = strobe_q;
    rej_d = 1'b0;
    rdata_d = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        RERP_ADR_FLAGS: begin
          if (mode_bad(reg_wdata) && !reg_wdata[RERP_BIT_RC])
            rej_d = 1'b1;
          else
            flags_d = reg_wdata & RERP_CHANGEABLE;
        end
        RERP_ADR_RD_RETRY: rd_retry_d = reg_wdata;
        RERP_ADR_WR_RETRY: wr_retry_d = reg_wdata;
        RERP_ADR_SPAN: begin
          if (reg_wdata == 8'h00)
            span_d = RERP_RST_SPAN;
          else if (reg_wdata < RERP_RST_SPAN || reg_wdata > RERP_MAX_SPAN)
            rej_d = 1'b1;
          else
            span_d = reg_wdata;
        end
        RERP_ADR_HEAD_OFS: head_d = reg_wdata;
        RERP_ADR_STROBE_OFS: begin
          if (reg_wdata > RERP_MAX_STROBE_OFS)
            rej_d = 1'b1;
          else
            strobe_d = reg_wdata;
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        RERP_ADR_FLAGS: rdata_d = flags_q;
        RERP_ADR_RD_RETRY: rdata_d = rd_retry_q;
        RERP_ADR_SPAN: rdata_d = span_q;
        RERP_ADR_HEAD_OFS: rdata_d = head_q;
        RERP_ADR_STROBE_OFS: rdata_d = strobe_q;
        RERP_ADR_WR_RETRY: rdata_d = wr_retry_q;
        RERP_ADR_TIME_LIMIT: rdata_d = RERP_TIME_LIMIT;
        RERP_ADR_CHANGEABLE: rdata_d = RERP_CHANGEABLE;
        RERP_ADR_STATUS: rdata_d = {4'h0, key_q};
        RERP_ADR_SENSE_LBA: rdata_d = sense_lba_q[7:0];
        RERP_ADR_SENSE: rdata_d = asc_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sector recovery sequencer
  // ------------------------------------------------------------
  always_comb begin
    rc = flags_q[RERP_BIT_RC] && !wr_op_q;
    eec = flags_q[RERP_BIT_EEC] && !rc;
    per = flags_q[RERP_BIT_PER] && !rc;
    stop_on_error_flag = flags_q[RERP_BIT_DTE] && !rc;
    no_correction_flag = flags_q[RERP_BIT_DCR] || rc;
    tb = flags_q[RERP_BIT_TB];
    mode_ok = !mode_bad(flags_q);
    limit = wr_op_q ? wr_retry_q : rd_retry_q;
    if (eec && limit > RERP_EARLY_TRIES)
      limit = RERP_EARLY_TRIES;
    if (rc)
      limit = 8'h00;
    st_d = st_q;
    att_d = att_q;
    lba_d = lba_q;
    wr_op_d = wr_op_q;
    sense_lba_d = sense_lba_q;
    sense_fatal_d = sense_fatal_q;
    key_d = rej_d ? RERP_KEY_ILLEGAL : key_q;
    asc_d = rej_d ? RERP_ASC_INV_PARAM : asc_q;
    try_req_d = 1'b0;
    ecc_d = 1'b0;
    done_d = 1'b0;
    send_d = 1'b0;
    stop_d = 1'b0;
    chk_d = rej_d;
    unique case (st_q)
      RERP_IDLE: begin
        if (sec_start) begin
          st_d = RERP_RETRY;
          att_d = 8'h00;
          lba_d = sec_lba;
          wr_op_d = sec_is_write;
          try_req_d = 1'b1;
        end
      end
      RERP_RETRY: begin
        if (try_done) begin
          if (try_ok) begin
            st_d = RERP_DONE;
            send_d = 1'b1;
            if (att_q != 8'h00) begin
              if (per && !sense_fatal_q) begin
                sense_lba_d = lba_q;
                key_d = RERP_KEY_RECOVERED;
              end
              if (per && stop_on_error_flag) begin
                stop_d = 1'b1;
                chk_d = 1'b1;
                send_d = tb;
              end
            end
          end else if (att_q < limit) begin
            att_d = att_q + 8'h01;
            try_req_d = 1'b1;
          end else if (try_ecc_fixable) begin
            // Correction off: a fixable error still counts as recovered
            st_d = RERP_CORRECT;
            ecc_d = !no_correction_flag;
          end else begin
            st_d = RERP_DONE;
            stop_d = !rc;
            chk_d = !rc;
            send_d = rc || tb;
            if (!rc && !sense_fatal_q) begin
              sense_lba_d = lba_q;
              sense_fatal_d = 1'b1;
              key_d = RERP_KEY_MEDIUM;
            end
          end
        end
      end
      RERP_CORRECT: begin
        st_d = RERP_DONE;
        send_d = 1'b1;
        if (per && !sense_fatal_q) begin
          sense_lba_d = lba_q;
          key_d = RERP_KEY_RECOVERED;
        end
        if (per && stop_on_error_flag && mode_ok) begin
          stop_d = 1'b1;
          chk_d = 1'b1;
          send_d = tb;
        end
      end
      RERP_DONE: begin
        st_d = RERP_IDLE;
        done_d = 1'b1;
      end
      default: st_d = RERP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_q <= RERP_RST_FLAGS;
      rd_retry_q <= RERP_RST_RD_RETRY;
      wr_retry_q <= RERP_RST_WR_RETRY;
      span_q <= RERP_RST_SPAN;
      head_q <= RERP_RST_HEAD_OFS;
      strobe_q <= RERP_RST_STROBE_OFS;
      rdata_q <= 8'h00;
      rej_q <= 1'b0;
      st_q <= RERP_IDLE;
      att_q <= 8'h00;
      lba_q <= 16'h0000;
      wr_op_q <= 1'b0;
      sense_lba_q <= 16'h0000;
      sense_fatal_q <= 1'b0;
      key_q <= 4'h0;
      asc_q <= 8'h00;
      try_req_q <= 1'b0;
      ecc_q <= 1'b0;
      done_q <= 1'b0;
      send_q <= 1'b0;
      stop_q <= 1'b0;
      chk_q <= 1'b0;
      pos_q <= RERP_POS_CENTER;
      neg_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      rd_retry_q <= rd_retry_d;
      wr_retry_q <= wr_retry_d;
      span_q <= span_d;
      head_q <= head_d;
      strobe_q <= strobe_d;
      rdata_q <= rdata_d;
      rej_q <= rej_d;
      st_q <= st_d;
      att_q <= att_d;
      lba_q <= lba_d;
      wr_op_q <= wr_op_d;
      sense_lba_q <= sense_lba_d;
      sense_fatal_q <= sense_fatal_d;
      key_q <= key_d;
      asc_q <= asc_d;
      try_req_q <= try_req_d;
      ecc_q <= ecc_d;
      done_q <= done_d;
      send_q <= send_d;
      stop_q <= stop_d;
      chk_q <= chk_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign try_req = try_req_q;
  assign try_pos = pos_q;
  assign try_neg = neg_q;
  assign ecc_req = ecc_q;
  assign ecc_span = span_q;
  assign sec_done = done_q;
  assign sec_send = send_q;
  assign xfer_stop = stop_q;
  assign check_cond = chk_q;
  assign param_reject = rej_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking chk_clk @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence rej_wr_s;
    reg_wr && reg_addr == RERP_ADR_FLAGS && mode_bad(reg_wdata) &&
      !reg_wdata[RERP_BIT_RC];
  endsequence
  bad_flags_a: assert property (rej_wr_s |=>
    param_reject && check_cond && $stable(flags_q))
    else $error("bad flag combination not rejected");
  mode_held_a: assert property (!flags_q[RERP_BIT_RC] |->
    !mode_bad(flags_q))
    else $error("invalid mode stored");
  time_lim_a: assert property (reg_rd &&
    reg_addr == RERP_ADR_TIME_LIMIT |=> reg_rdata == 8'h00)
    else $error("time limit not zero");
  chg_val_a: assert property (reg_rd &&
    reg_addr == RERP_ADR_CHANGEABLE |=> reg_rdata[2:0] == 3'h7)
    else $error("changeable bits wrong");
  span_rng_a: assert property (span_q >= RERP_RST_SPAN &&
    span_q <= RERP_MAX_SPAN)
    else $error("span out of range");
  strobe_rng_a: assert property (strobe_q <= RERP_MAX_STROBE_OFS)
    else $error("strobe count out of range");
  retry_lim_a: assert property (st_q == RERP_RETRY |->
    att_q <= limit)
    else $error("attempts beyond limit");
  no_ecc_a: assert property (no_correction_flag |-> !ecc_d)
    else $error("correction while disabled");
  fatal_stop_a: assert property (st_q == RERP_RETRY && try_done &&
    !try_ok && att_q >= limit && !try_ecc_fixable && !rc |=>
    xfer_stop ##1 sec_done)
    else $error("unrecoverable error did not stop");
  cont_read_a: assert property (rc && st_q != RERP_IDLE |->
    !try_req_d && !xfer_stop)
    else $error("continuous read retried or stopped");
endmodule : rerp_core
`default_nettype wire

/* test/rerp_channel_model.sv */
// Purpose: read channel model answering recovery attempt requests
// Assumes: one attempt in flight at a time
// Notes: attempts up to fail_n fail, later ones succeed
`timescale 1ns/100ps
`default_nettype none
module rerp_channel_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sec_start,
  input wire logic try_req,
  input wire logic [7:0] fail_n,
  input wire logic fix_in,
  input wire logic [1:0] lat,
  output logic try_done,
  output logic try_ok,
  output logic try_ecc_fixable
);
  // ------------------------------------------------------------
  // Attempt answer
  // ------------------------------------------------------------
  logic [7:0] tries_q;
  logic [1:0] wait_q;
  logic pend_q;
  // Result lines toggle between answers, never hold a stale value
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tries_q <= 8'h00;
      wait_q <= 2'h0;
      pend_q <= 1'b0;
      try_done <= 1'b0;
      try_ok <= 1'b0;
      try_ecc_fixable <= 1'b0;
    end else begin
      try_done <= 1'b0;
      try_ok <= ~try_ok;
      try_ecc_fixable <= ~try_ecc_fixable;
      if (sec_start) begin
        tries_q <= 8'h00;
      end
      if (try_req) begin
        tries_q <= tries_q + 8'h01;
        wait_q <= lat;
        pend_q <= 1'b1;
      end else if (pend_q && wait_q == 2'h0) begin
        pend_q <= 1'b0;
        try_done <= 1'b1;
        try_ok <= (tries_q > fail_n);
        try_ecc_fixable <= fix_in;
      end else if (pend_q) begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
endmodule : rerp_channel_model
`default_nettype wire

/* test/read_error_recovery_policy_bench.sv */
// Purpose: self-checking bench for the recovery policy core
// Assumes: channel model on the attempt interface
// Notes: expectations worked out from mode table and defaults
`timescale 1ns/100ps
`default_nettype none
module read_error_recovery_policy_bench;
  import rerp_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sec_start = 1'b0;
  logic sec_is_write = 1'b0;
  logic [15:0] sec_lba = 16'h0000;
  logic try_done, try_ok, try_ecc_fixable, try_req, try_neg, ecc_req;
  logic sec_done, sec_send, xfer_stop, check_cond, param_reject;
  rerp_pos_t try_pos;
  logic [7:0] ecc_span;
  logic [7:0] fail_n = 8'h00;
  logic fix_in = 1'b0;
  logic [1:0] lat = 2'h0;
  int failures = 0;
  int samples_checked = 0;
  int n_try, n_ecc, n_send, n_stop, n_chk;
  rerp_pos_t pos_q[$];
  logic neg_q[$];
  always #25 clk_sys = ~clk_sys;
  rerp_core u_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sec_start(sec_start),
    .sec_is_write(sec_is_write), .sec_lba(sec_lba), .try_done(try_done),
    .try_ok(try_ok), .try_ecc_fixable(try_ecc_fixable), .try_req(try_req),
    .try_pos(try_pos), .try_neg(try_neg), .ecc_req(ecc_req),
    .ecc_span(ecc_span), .sec_done(sec_done), .sec_send(sec_send),
    .xfer_stop(xfer_stop), .check_cond(check_cond),
    .param_reject(param_reject));
  rerp_channel_model u_chan (.clk_sys(clk_sys), .reset(reset),
    .sec_start(sec_start), .try_req(try_req), .fail_n(fail_n),
    .fix_in(fix_in), .lat(lat), .try_done(try_done), .try_ok(try_ok),
    .try_ecc_fixable(try_ecc_fixable));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task stop_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task check(input string name, input logic [15:0] exp,
             input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task reg_write(input logic [3:0] a, input logic [7:0] d,
                 output logic rej, output logic chk);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
    rej = param_reject;
    chk = check_cond;
  endtask : reg_write
  task reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read
  // Latency alternates so both prompt and slow answers occur
  task sector_case(input logic [7:0] flags, input logic wr,
    input logic [15:0] lba, input logic [7:0] fails, input logic fix,
    input int tries, input int ecc, input int send, input int stop,
    input int chk);
    logic rej, cc;
    int i;
    reg_write(RERP_ADR_FLAGS, flags, rej, cc);
    n_try = 0; n_ecc = 0; n_send = 0; n_stop = 0; n_chk = 0;
    pos_q.delete();
    neg_q.delete();
    @(posedge clk_sys);
    fail_n <= fails;
    fix_in <= fix;
    lat <= lat ^ 2'h3;
    sec_start <= 1'b1;
    sec_is_write <= wr;
    sec_lba <= lba;
    @(posedge clk_sys);
    sec_start <= 1'b0;
    for (i = 0; i < 2000; i++) begin
      #1;
      if (try_req === 1'b1) begin
        n_try++;
        pos_q.push_back(try_pos);
        neg_q.push_back(try_neg);
      end
      if (ecc_req === 1'b1) n_ecc++;
      if (sec_send === 1'b1) n_send++;
      if (xfer_stop === 1'b1) n_stop++;
      if (check_cond === 1'b1) n_chk++;
      if (sec_done === 1'b1) break;
      @(posedge clk_sys);
    end
    if (i == 2000) begin
      failures++;
      $display("CHECK FAILED sec_done expected 1 seen 0");
      stop_test();
    end
    check("try_req count", tries[15:0], n_try[15:0]);
    check("ecc_req count", ecc[15:0], n_ecc[15:0]);
    check("sec_send count", send[15:0], n_send[15:0]);
    check("xfer_stop count", stop[15:0], n_stop[15:0]);
    if (chk >= 0) check("check_cond count", chk[15:0], n_chk[15:0]);
  endtask : sector_case
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset_values;
    logic [7:0] exp_v [8];
    logic [7:0] d;
    exp_v = '{8'h00, 8'h0A, 8'h0B, 8'h02, 8'h02, 8'h04, 8'h00, 8'h3F};
    for (int a = 0; a < 8; a++) begin
      reg_read(a[3:0], d);
      check("reset value", {8'h00, exp_v[a]}, {8'h00, d});
    end
    check("ecc_span", 16'h000B, {8'h00, ecc_span});
  endtask : t_reset_values
  task t_flag_modes;
    logic rej, cc, bad;
    logic [7:0] d, good;
    good = 8'h00;
    for (int m = 0; m < 16; m++) begin
      bad = (m inside {2, 3, 9, 10, 11, 13, 15});
      reg_write(RERP_ADR_FLAGS, m[7:0], rej, cc);
      check("param_reject", {15'h0, bad}, {15'h0, rej});
      check("check_cond", {15'h0, bad}, {15'h0, cc});
      if (bad) begin
        reg_read(RERP_ADR_SENSE, d);
        check("asc", 16'h0026, {8'h00, d});
        reg_read(RERP_ADR_STATUS, d);
        check("sense key", 16'h0005, {12'h000, d[3:0]});
        reg_read(RERP_ADR_FLAGS, d);
        check("flags kept", {8'h00, good}, {8'h00, d});
      end else begin
        good = m[7:0];
      end
    end
    reg_write(RERP_ADR_FLAGS, 8'h1A, rej, cc);
    check("reject with rc", 16'h0000, {15'h0, rej});
  endtask : t_flag_modes
  // Row: address, data, reject (2 = not judged), read back
  task t_field_limits;
    logic [23:0] rows [11];
    logic rej, cc;
    logic [7:0] d;
    rows = '{24'h214014, 24'h20000B, 24'h20A10B, 24'h21510B, 24'h403102,
      24'h400000, 24'h402002, 24'h1FF0FF, 24'h10A00A, 24'h655200,
      24'hF7721A};
    for (int r = 0; r < 11; r++) begin
      reg_write(rows[r][23:20], rows[r][19:12], rej, cc);
      if (rows[r][11:8] != 4'h2) begin
        check("field reject", {12'h0, rows[r][11:8]}, {15'h0, rej});
      end
      reg_read(rows[r][23:20] == 4'hF ? RERP_ADR_FLAGS : rows[r][23:20], d);
      check("field value", {8'h00, rows[r][7:0]}, {8'h00, d});
    end
  endtask : t_field_limits
  task t_plain_and_exhaust;
    rerp_pos_t ep [8];
    logic [7:0] en;
    ep = '{RERP_POS_CENTER, RERP_POS_CENTER, RERP_POS_CENTER,
      RERP_POS_CENTER, RERP_POS_HEAD, RERP_POS_HEAD, RERP_POS_STROBE,
      RERP_POS_STROBE};
    en = 8'h05;
    sector_case(8'h00, 1'b0, 16'h0011, 8'h02, 1'b0, 3, 0, 1, 0, 0);
    sector_case(8'h00, 1'b0, 16'h0012, 8'hFF, 1'b1, 11, 1, 1, 0, 0);
    for (int k = 0; k < 8; k++) begin
      check("try_pos", {14'h0, ep[k]}, {14'h0, pos_q[k]});
      check("try_neg", {15'h0, en[7 - k]}, {15'h0, neg_q[k]});
    end
    sector_case(8'h08, 1'b0, 16'h0013, 8'hFF, 1'b1, 2, 1, 1, 0, 0);
  endtask : t_plain_and_exhaust
  task t_stop_modes;
    logic [7:0] d;
    // Stop flag only with post flag
    sector_case(8'h06, 1'b0, 16'h0033, 8'h01, 1'b0, 2, 0, 0, 1, 1);
    reg_read(RERP_ADR_SENSE_LBA, d);
    check("sense lba", 16'h0033, {8'h00, d});
    sector_case(8'h26, 1'b0, 16'h0034, 8'h01, 1'b0, 2, 0, 1, 1, 1);
    sector_case(8'h04, 1'b0, 16'h0035, 8'h01, 1'b0, 2, 0, 1, 0, -1);
  endtask : t_stop_modes
  task t_unrecoverable;
    logic [7:0] d;
    sector_case(8'h01, 1'b0, 16'h0055, 8'hFF, 1'b1, 11, 0, 1, 0, 0);
    sector_case(8'h01, 1'b0, 16'h0056, 8'hFF, 1'b0, 11, 0, 0, 1, 1);
    sector_case(8'h21, 1'b0, 16'h0057, 8'hFF, 1'b0, 11, 0, 1, 1, 1);
    sector_case(8'h04, 1'b0, 16'h0078, 8'h01, 1'b0, 2, 0, 1, 0, -1);
    reg_read(RERP_ADR_SENSE_LBA, d);
    check("sense lba", 16'h0056, {8'h00, d});
    sector_case(8'h1A, 1'b0, 16'h0079, 8'hFF, 1'b1, 1, 0, 1, 0, 0);
    sector_case(8'h00, 1'b1, 16'h007A, 8'hFF, 1'b0, 5, 0, 0, 1, 1);
  endtask : t_unrecoverable
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset_values();
    t_flag_modes();
    t_field_limits();
    t_plain_and_exhaust();
    t_stop_modes();
    t_unrecoverable();
    stop_test();
  end
endmodule : read_error_recovery_policy_bench
`default_nettype wire
